// ===== design/ees_slave.sv
// Two-wire bus slave front end of a small serial EEPROM.
// How it works
// R01: Power-up enters standby, logic in known state.
// R02: Supply loss forces the reset state again.
// R03: No commands accepted before power-up delay.
// R04: Sample on clock rise, change after fall.
// R05: Undriven chip-select straps read as zero.
// R06: Write protect high blocks all memory writes.
// R07: Master makes clock, START and STOP.
// R08: Pull low for zero, release for one.
// R09: Master starts only on an idle bus.
// R10: Data change with clock high is START/STOP.
// R11: START is data falling while clock high.
// R12: Without START, all activity is ignored.
// R13: STOP is data rising while clock high.
// R14: Address upper nibble must equal 1010.
// R15: Chip-selects match straps; third bit is address.
// R16: Last address bit: one reads, zero writes.
// R17: Matching address acknowledged on ninth clock.
// R18: Write address and data bytes acknowledged.
// R19: Read shifts eight bits, releases on ninth.
// R20: Keep sending while the master acknowledges.
// R21: Pulses up to 50 ns are filtered out.
// R22: Busy with internal write: data released.
// R23: Addressed while busy: no acknowledge.
// R24: Extension bits: cs high, cs low, address msb.
// R25: Mismatch: no acknowledge, idle until START.
`include "ees_regs.svh"
`default_nettype none
module ees_slave
  import ees_pkg::*;
#(
  parameter int READY_CYC = `EES_POWERUP_CYC,
  parameter int FILTER_CYC = `EES_GLITCH_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic chip_select_strap_high,
  input wire logic chip_select_strap_low,
  input wire logic write_protect,
  input wire logic write_busy,
  input wire logic [7:0] read_data,
  output logic memory_address_msb,
  output logic is_read,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_first,
  output logic read_next,
  output logic cmd_end,
  output logic write_blocked
);

  // Reset release through two flip-flops. Supply loss shows as nrst low,
  // which forces every flip-flop back to its reset value.
  logic rst_s0_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s0_r <= 1'b0; // R02
      rst_n <= 1'b0; // R01
    end else begin
      rst_s0_r <= 1'b1;
      rst_n <= rst_s0_r;
    end
  end

  // Filtered bus levels and the power-up ready flag.
  ees_bus_s bus;
  logic ready;

  ees_glitch_filter #(.FILTER_CYC(FILTER_CYC)) u_scl_filt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(scl_in),
    .level_out(bus.scl)
  );

  ees_glitch_filter #(.FILTER_CYC(FILTER_CYC)) u_sda_filt (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pin_in(sda_in),
    .level_out(bus.sda)
  );

  ees_powerup_timer #(.READY_CYC(READY_CYC)) u_pu (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ready(ready)
  );

  // Straps are pins from outside, so they pass two flip-flops. A strap
  // left open is pulled low in the pad, which reads here as zero.
  ees_strap_s strap_s0_r;
  ees_strap_s strap_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s0_r <= '0;
      strap_r <= '0;
    end else begin
      strap_s0_r <= {chip_select_strap_high, chip_select_strap_low,
                     write_protect}; // R05
      strap_r <= strap_s0_r;
    end
  end

  // Previous filtered levels for edge detection.
  ees_bus_s prev_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      prev_r <= bus;
    end
  end

  // Edges of the filtered levels. A data edge with clock high is always
  // a bus condition, never data.
  always_comb begin
    scl_rise = bus.scl && !prev_r.scl;
    scl_fall = !bus.scl && prev_r.scl;
    start_det = bus.scl && prev_r.scl && prev_r.sda && !bus.sda; // R11 R10
    stop_det = bus.scl && prev_r.scl && !prev_r.sda && bus.sda; // R13 R10
  end

  // Returns whether a slave address selects this device.
  function automatic logic addr_match(input logic [7:0] a,
                                      input ees_strap_s s);
    addr_match = (a[7:4] == `EES_TYPE_CODE) && // R14
      (a[`EES_POS_CS_HIGH] == s.cs_high) && // R15 R24
      (a[`EES_POS_CS_LOW] == s.cs_low);
  endfunction

  // Protocol state.
  ees_state_e state_r, state_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic ack_r, ack_nxt; // Master acknowledge sampled in the MACK slot.
  logic read_r, read_nxt;
  logic first_r, first_nxt; // Next received byte is the word address.
  logic msb_r, msb_nxt;
  logic oe_r, oe_nxt;
  logic rxv_r, rxv_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic rxf_r, rxf_nxt;
  logic rdn_r, rdn_nxt;
  logic end_r, end_nxt;
  logic wblk_r, wblk_nxt;

  // One process computes the whole next protocol state. Sampling is on
  // the clock rise and the data pin only moves after the clock fall.
  always_comb begin
    state_nxt = state_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    ack_nxt = ack_r;
    read_nxt = read_r;
    first_nxt = first_r;
    msb_nxt = msb_r;
    oe_nxt = oe_r;
    rxv_nxt = 1'b0;
    rxd_nxt = rxd_r;
    rxf_nxt = rxf_r;
    rdn_nxt = 1'b0;
    end_nxt = 1'b0;
    wblk_nxt = wblk_r;
    if (!ready) begin
      state_nxt = EES_IDLE; // R03
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = EES_ADDR; // R11
      bit_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else if (stop_det) begin
      state_nxt = EES_IDLE; // R13
      oe_nxt = 1'b0;
      end_nxt = 1'b1;
    end else begin
      case (state_r)
        EES_IDLE: begin
          oe_nxt = 1'b0; // R12 R25
        end
        EES_ADDR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], bus.sda}; // R04
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h8) begin
            if (addr_match(shift_r, strap_r) && !write_busy) begin
              ack_nxt = 1'b1; // R17
              oe_nxt = 1'b1;
              read_nxt = shift_r[`EES_POS_DIR]; // R16
              msb_nxt = shift_r[`EES_POS_ADDR_MSB]; // R15
              first_nxt = 1'b1;
              wblk_nxt = 1'b0;
              state_nxt = EES_ACK;
            end else begin
              state_nxt = EES_IDLE; // R23 R25 R22
            end
          end
        end
        EES_ACK: begin
          // The acknowledge is held low through the ninth clock.
          if (scl_fall) begin
            bit_nxt = 4'h0;
            if (read_r) begin
              shift_nxt = read_data;
              rdn_nxt = 1'b1;
              oe_nxt = !read_data[7]; // R19 R08
              state_nxt = EES_SEND;
            end else begin
              oe_nxt = 1'b0;
              state_nxt = EES_RECV;
            end
          end
        end
        EES_RECV: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], bus.sda}; // R04
            bit_nxt = bit_r + 4'h1;
          end else if (scl_fall && bit_r == 4'h7 && !first_r) begin
            // Protect is strobed on the fall before the last bit of each data byte.
            wblk_nxt = strap_r.write_protect; // R06
          end else if (scl_fall && bit_r == 4'h8) begin
            first_nxt = 1'b0;
            if (!first_r && wblk_r) begin
              // A refused byte is never handed on as received.
              state_nxt = EES_IDLE; // R06
              oe_nxt = 1'b0;
            end else begin
              rxv_nxt = 1'b1;
              rxd_nxt = shift_r;
              rxf_nxt = first_r;
              oe_nxt = 1'b1; // R18
              state_nxt = EES_ACK;
            end
          end
        end
        EES_SEND: begin
          if (scl_fall) begin
            if (bit_r == 4'h7) begin
              oe_nxt = 1'b0; // R19
              state_nxt = EES_MACK;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = !shift_r[6]; // R04 R08
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        EES_MACK: begin
          if (scl_rise) begin
            ack_nxt = !bus.sda;
          end else if (scl_fall) begin
            if (ack_r) begin
              shift_nxt = read_data; // R20
              rdn_nxt = 1'b1;
              oe_nxt = !read_data[7];
              bit_nxt = 4'h0;
              state_nxt = EES_SEND;
            end else begin
              state_nxt = EES_IDLE; // R20
            end
          end
        end
        default: begin
          state_nxt = EES_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // Registers of the protocol state.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= EES_IDLE; // R01
      shift_r <= 8'h00;
      bit_r <= 4'h0;
      ack_r <= 1'b0;
      read_r <= 1'b0;
      first_r <= 1'b0;
      msb_r <= 1'b0;
      oe_r <= 1'b0;
      rxv_r <= 1'b0;
      rxd_r <= 8'h00;
      rxf_r <= 1'b0;
      rdn_r <= 1'b0;
      end_r <= 1'b0;
      wblk_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      ack_r <= ack_nxt;
      read_r <= read_nxt;
      first_r <= first_nxt;
      msb_r <= msb_nxt;
      oe_r <= oe_nxt;
      rxv_r <= rxv_nxt;
      rxd_r <= rxd_nxt;
      rxf_r <= rxf_nxt;
      rdn_r <= rdn_nxt;
      end_r <= end_nxt;
      wblk_r <= wblk_nxt;
    end
  end

  // Open drain: the pin only ever pulls low.
  assign sda_out = 1'b0; // R08
  assign sda_oe = oe_r;
  assign memory_address_msb = msb_r;
  assign is_read = read_r;
  assign rx_valid = rxv_r;
  assign rx_data = rxd_r;
  assign rx_first = rxf_r;
  assign read_next = rdn_r;
  assign cmd_end = end_r;
  assign write_blocked = wblk_r;

endmodule
`default_nettype wire

// ===== design/ees_regs.svh
// Constants for the serial EEPROM slave front end.
`ifndef EES_REGS_SVH
`define EES_REGS_SVH

// Fixed device type nibble of the slave address.
`define EES_TYPE_CODE 4'ha
// Slave address bit positions.
`define EES_POS_CS_HIGH 3
`define EES_POS_CS_LOW 2
`define EES_POS_ADDR_MSB 1
`define EES_POS_DIR 0
// Power-up to ready delay in microseconds (0.35 ms).
`define EES_POWERUP_US 350
// Glitch filter width in nanoseconds.
`define EES_GLITCH_NS 50
// Clock period in nanoseconds (200 MHz).
`define EES_CLK_NS 5
// Cycles for the power-up delay, rounded down as a longest time.
`define EES_POWERUP_CYC ((`EES_POWERUP_US * 1000) / `EES_CLK_NS)
// Cycles for the glitch filter, rounded up as a least time.
`define EES_GLITCH_CYC ((`EES_GLITCH_NS + `EES_CLK_NS - 1) / `EES_CLK_NS)

`endif

// ===== design/ees_pkg.sv
// Types shared by the serial EEPROM slave front end.
`default_nettype none
package ees_pkg;

  // Protocol state of the slave.
  typedef enum logic [2:0] {
    EES_IDLE,
    EES_ADDR,
    EES_ACK,
    EES_RECV,
    EES_SEND,
    EES_MACK
  } ees_state_e;

  // Filtered and synchronised bus levels.
  typedef struct packed {
    logic scl;
    logic sda;
  } ees_bus_s;

  // Static strap and protect levels.
  typedef struct packed {
    logic cs_high;
    logic cs_low;
    logic write_protect;
  } ees_strap_s;

endpackage
`default_nettype wire

// ===== design/ees_glitch_filter.sv
// Synchroniser and glitch filter for one bus input.
`include "ees_regs.svh"
`default_nettype none
module ees_glitch_filter
  import ees_pkg::*;
#(
  parameter int FILTER_CYC = `EES_GLITCH_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level_out
);

  initial begin
    if (FILTER_CYC < 1 || FILTER_CYC > 255) begin
      $error("FILTER_CYC out of range");
    end
  end

  // Two-stage synchroniser; only the second stage is read further on.
  logic sync0_r;
  logic sync1_r;
  // Filtered level and how long the input has disagreed with it.
  logic level_r;
  logic level_nxt;
  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;

  // A new level is taken only once it has held past the filter width.
  always_comb begin
    level_nxt = level_r;
    cnt_nxt = 8'h00;
    if (sync1_r != level_r) begin
      if (cnt_r >= 8'(FILTER_CYC)) begin
        level_nxt = sync1_r; // R21
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  // Idle bus is high, so the filter starts high.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync0_r <= 1'b1;
      sync1_r <= 1'b1;
      level_r <= 1'b1;
      cnt_r <= 8'h00;
    end else begin
      sync0_r <= pin_in;
      sync1_r <= sync0_r;
      level_r <= level_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign level_out = level_r;

endmodule
`default_nettype wire

// ===== design/ees_powerup_timer.sv
// Power-up ready timer held in reset while the supply is low.
`include "ees_regs.svh"
`default_nettype none
module ees_powerup_timer
  import ees_pkg::*;
#(
  parameter int READY_CYC = `EES_POWERUP_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic ready
);

  initial begin
    if (READY_CYC < 1 || READY_CYC >= (1 << 20)) begin
      $error("READY_CYC out of range");
    end
  end

  // Counts cycles since reset release; reaching the end means ready.
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic ready_r;
  logic ready_nxt;

  // Count up once, then hold ready until the next reset.
  always_comb begin
    cnt_nxt = cnt_r;
    ready_nxt = ready_r;
    if (!ready_r) begin
      if (cnt_r >= 20'(READY_CYC - 1)) begin
        ready_nxt = 1'b1; // R03
      end else begin
        cnt_nxt = cnt_r + 20'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 20'h00000;
      ready_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ready_r <= ready_nxt;
    end
  end

  assign ready = ready_r;

endmodule
`default_nettype wire

// ===== verification/ees_slave_assertions.sv
// Port-level checks on the EEPROM slave front end.
`default_nettype none
module ees_slave_assertions
  import ees_pkg::*;
#(
  parameter int READY_CYC = 50
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_busy,
  input wire logic is_read,
  input wire logic rx_valid,
  input wire logic read_next,
  input wire logic cmd_end,
  input wire logic write_blocked
);
  timeunit 1ns;
  timeprecision 100ps;
  // Cycles since reset release, saturating at the ready point. Wide
  // enough for the full power-up delay at the default clock.
  logic [19:0] up_cnt_r;
  logic [19:0] up_cnt_nxt;
  always_comb begin
    up_cnt_nxt = (up_cnt_r < 20'(READY_CYC)) ?
      up_cnt_r + 20'h00001 : up_cnt_r;
  end
  // Raw reset is used, so the count is never later than the design's own.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      up_cnt_r <= 20'h00000;
    end else begin
      up_cnt_r <= up_cnt_nxt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_od_low; sda_out == 1'b0; endproperty
  a_od_low: assert property (p_od_low)
    else $error("data pin driven high");
  property p_early; sda_oe |-> up_cnt_r >= 20'(READY_CYC); endproperty
  a_early: assert property (p_early)
    else $error("bus answered before ready");
  property p_busy; write_busy |-> !sda_oe; endproperty
  a_busy: assert property (p_busy)
    else $error("data driven while busy");
  property p_edge; $changed(sda_oe) |-> !scl_in; endproperty
  a_edge: assert property (p_edge)
    else $error("data changed with clock high");
  property p_rx_ack; rx_valid |-> ##[0:2] sda_oe; endproperty
  a_rx_ack: assert property (p_rx_ack)
    else $error("received byte not acknowledged");
  property p_rx_pulse; rx_valid |=> !rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe too long");
  property p_rn; read_next |-> is_read ##1 !read_next; endproperty
  a_rn: assert property (p_rn)
    else $error("read load outside a read");
  property p_end; cmd_end |=> !cmd_end; endproperty
  a_end: assert property (p_end)
    else $error("end strobe too long");
  property p_wp; write_blocked |-> !is_read && !rx_valid; endproperty
  a_wp: assert property (p_wp)
    else $error("blocked write still took data");
endmodule
bind ees_slave ees_slave_assertions #(.READY_CYC(READY_CYC)) u_chk (
  .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .write_busy(write_busy), .is_read(is_read),
  .rx_valid(rx_valid), .read_next(read_next), .cmd_end(cmd_end),
  .write_blocked(write_blocked));
`default_nettype wire

// ===== verification/ees_master_model.sv
// Two-wire bus master model that makes the bus clock and the frames.
`default_nettype none
module ees_master_model (
  output var logic scl,
  output var logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quarter of the 80 ns bus clock period.
  localparam int Q = 20;
  // The bus idles high through its pull-ups; the clock stands still.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // START from idle, or repeated START from a low clock.
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // STOP, then a bus-free gap so the next frame starts on an idle bus.
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #(3 * Q);
  endtask
  // One bit: data moves only while the clock is low.
  task automatic bit_x(input logic b, output logic r);
    sda_low = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Eight bits MSB first, then the ninth; a is high when it was low.
  task automatic xfer(input logic [7:0] d, input logic b9,
                      output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(b9, r);
    a = ~r;
    sda_low = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/ees_slave_tb_top.sv
// Self-checking bench for the EEPROM slave front end.
`default_nettype none
`include "ees_regs.svh"
module ees_slave_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ees_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic strap_hi = 1'b1;
  logic strap_lo = 1'b0;
  logic wp = 1'b0;
  logic busy = 1'b0;
  logic glitch = 1'b0; // Short low pulse forced onto the data input.
  logic m_scl, m_low, sda_w, sda_out, sda_oe, msb, is_read, rx_valid;
  logic rx_first, read_next, cmd_end, wblk;
  logic [7:0] rx_data, read_data;
  logic [7:0] rd_tab [2] = '{8'ha5, 8'h3c}; // Bytes served to reads.
  int rd_i = 0;
  int ends = 0;
  int miscompares = 0;
  int check_count = 0;
  logic [8:0] rx_q [$]; // Acked bytes with their first-byte mark.
  // Open-drain wire: low if either side pulls, else the pull-up wins.
  assign sda_w = ~m_low & ~(sda_oe & ~sda_out);
  assign read_data = rd_tab[rd_i[0]];
  always #2.5 sys_clk = ~sys_clk;
  ees_master_model m (.scl(m_scl), .sda_low(m_low), .sda(sda_w));
  // Filter shortened so the 80 ns bus clock passes; glitches of 5 ns die.
  ees_slave #(.READY_CYC(50), .FILTER_CYC(2)) uut (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(m_scl),
    .sda_in(sda_w & ~glitch), .sda_out(sda_out), .sda_oe(sda_oe),
    .chip_select_strap_high(strap_hi), .chip_select_strap_low(strap_lo),
    .write_protect(wp), .write_busy(busy), .read_data(read_data),
    .memory_address_msb(msb), .is_read(is_read), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_first(rx_first), .read_next(read_next),
    .cmd_end(cmd_end), .write_blocked(wblk));
  // Record acked bytes and stop pulses for later comparison. Sampled
  // mid-cycle, where the registered pulses have settled.
  always @(negedge sys_clk) begin
    if (rx_valid === 1'b1) rx_q.push_back({rx_first, rx_data});
    if (cmd_end === 1'b1) ends++;
  end
  // Serve the next byte each time the slave loads one.
  always @(negedge sys_clk) if (read_next === 1'b1) rd_i++;
  function automatic logic [7:0] ab(input logic dir, input logic hi_bit);
    return {`EES_TYPE_CODE, strap_hi, strap_lo, hi_bit, dir};
  endfunction
  task automatic chk(input string n, input logic [8:0] e,
                     input logic [8:0] g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Address, word address and data byte, all acked; the last two reported.
  task automatic t_write();
    logic [7:0] q;
    logic a;
    rx_q.delete();
    ends = 0;
    m.start();
    m.xfer(ab(1'b0, 1'b1), 1'b1, q, a);
    chk("addr_ack", 1, a);
    chk("addr_msb", 1, msb);
    chk("dir_write", 0, is_read);
    m.xfer(8'h5a, 1'b1, q, a);
    chk("word_ack", 1, a);
    m.xfer(8'hc3, 1'b1, q, a);
    chk("data_ack", 1, a);
    m.stop();
    chk("rx_word", 9'h15a, rx_q[0]);
    chk("rx_data", 9'h0c3, rx_q[1]);
    chk("stop_seen", 1, ends);
  endtask
  // Two bytes: the first acked by the master, the second not.
  task automatic t_read();
    logic [7:0] q;
    logic a;
    rd_i = 0;
    m.start();
    m.xfer(ab(1'b1, 1'b0), 1'b1, q, a);
    chk("rd_addr_ack", 1, a);
    chk("dir_read", 1, is_read);
    m.xfer(8'hff, 1'b0, q, a);
    chk("rd_byte0", 8'ha5, q);
    m.xfer(8'hff, 1'b1, q, a);
    chk("rd_byte1", 8'h3c, q);
    chk("rd_release", 0, a);
    m.stop();
    chk("rd_loads", 2, 9'(rd_i));
  endtask
  // Wrong type nibble and wrong straps: no ack, then silence.
  task automatic t_refuse();
    logic [7:0] q;
    logic a;
    logic [7:0] bad [3];
    bad = '{ab(1'b0, 1'b0) ^ 8'h10, ab(1'b0, 1'b0) ^ 8'h08,
            ab(1'b0, 1'b0) ^ 8'h04};
    foreach (bad[i]) begin
      m.start();
      m.xfer(bad[i], 1'b1, q, a);
      chk("bad_addr", 0, a);
      m.xfer(8'h00, 1'b1, q, a);
      chk("bad_idle", 0, a);
      m.stop();
    end
  endtask
  // Busy with a write: no ack; once done, ack again.
  task automatic t_busy();
    logic [7:0] q;
    logic a;
    for (int i = 1; i >= 0; i--) begin
      busy = i[0];
      m.start();
      m.xfer(ab(1'b0, 1'b0), 1'b1, q, a);
      chk("busy_ack", 9'(1 - i), a);
      m.stop();
    end
  endtask
  // Write protect high: the first data byte is refused.
  task automatic t_wp();
    logic [7:0] q;
    logic a;
    wp = 1'b1;
    m.start();
    m.xfer(ab(1'b0, 1'b0), 1'b1, q, a);
    m.xfer(8'h10, 1'b1, q, a);
    chk("wp_word_ack", 1, a);
    m.xfer(8'h77, 1'b1, q, a);
    chk("wp_data_ack", 0, a);
    chk("wp_blocked", 1, wblk);
    m.stop();
    wp = 1'b0;
  endtask
  // A 5 ns data glitch with clock high must not pass for a START.
  task automatic t_nostart();
    logic [7:0] q;
    logic a;
    @(negedge sys_clk) glitch = 1'b1;
    @(negedge sys_clk) glitch = 1'b0;
    m.xfer(ab(1'b0, 1'b0), 1'b1, q, a);
    chk("nostart_ack", 0, a);
    m.stop();
  endtask
  // Reset in mid-command, then a command before the ready delay.
  task automatic t_power();
    logic [7:0] q;
    logic a;
    m.start();
    m.xfer(ab(1'b1, 1'b0), 1'b1, q, a);
    nrst = 1'b0;
    #1 chk("rst_dir", 0, is_read);
    @(negedge sys_clk) nrst = 1'b1;
    m.stop();
    m.start();
    m.xfer(ab(1'b0, 1'b0), 1'b1, q, a);
    chk("early_ack", 0, a);
    m.stop();
  endtask
  // Whole run is near 17 us; a hang is cut off well beyond that.
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (20) @(negedge sys_clk);
    nrst = 1'b1;
    repeat (60) @(negedge sys_clk);
    // The read goes first so that the write must turn the direction back.
    t_read();
    t_write();
    t_refuse();
    t_busy();
    t_wp();
    t_nostart();
    t_power();
    summarize();
  end
endmodule
`default_nettype wire
